// file: rtl/lvds_rx_config_regs.sv
/*
 Input receiver configuration bank: per-pin receiver enables and receiver
 delay, reference and clocking controls, reached over classic Wishbone.
 Assumes a single 250 MHz clock and a synchronous active-low reset.
*/
// Design decision made here: the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "lvds_rx_cfg.svh"
module lvds_rx_config_regs
    import lvds_rx_pkg::*;
(
    input  wire logic        CORE_CLK_IN,
    input  wire logic        RESET_N_IN,
    input  wire logic        WB_CYC_IN,
    input  wire logic        WB_STB_IN,
    input  wire logic        WB_WE_IN,
    input  wire logic [5:0]  WB_ADR_IN,
    input  wire logic [3:0]  WB_SEL_IN,
    input  wire logic [31:0] WB_DAT_IN,
    output var  logic [31:0] WB_DAT_OUT,
    output var  logic        WB_ACK_OUT,
    output var  logic [6:0]  PORT_A_DATA_PINS_EN_OUT,
    output var  logic [6:0]  PORT_B_DATA_PINS_EN_OUT,
    output var  logic [2:0]  PORT_A_DATA_DELAY_OUT,
    output var  logic [2:0]  SYNC_OR_PORT_A_CLOCK_DELAY_OUT,
    output var  logic [2:0]  SHARED_OR_PORT_B_DATA_DELAY_OUT,
    output var  logic [2:0]  SHARED_OR_PORT_B_CLOCK_DELAY_OUT,
    output var  logic        EXT_REF_ENABLE_OUT,
    output var  logic        DUAL_CLOCK_ENABLE_OUT
);
    // Nominal delay of one code step, for downstream timing models
    localparam int DELAY_STEP_PS = `DELAY_STEP_PS;

    typedef struct packed {
        reg_word_t input_receiver_enable;
        reg_word_t receiver_delay_control;
    } regs_s;

    regs_s       q;
    regs_s       next_q;
    reg_word_t   lane_mask;
    lvds_rx_bus_if bus ();

    lvds_rx_wb_slave u_wb (
        .clk_in     (CORE_CLK_IN),
        .reset_n_in (RESET_N_IN),
        .cyc_in     (WB_CYC_IN),
        .stb_in     (WB_STB_IN),
        .we_in      (WB_WE_IN),
        .adr_in     (WB_ADR_IN),
        .dat_in     (WB_DAT_IN),
        .dat_out    (WB_DAT_OUT),
        .ack_out    (WB_ACK_OUT),
        .bus        (bus)
    );

    assign lane_mask = {{8{WB_SEL_IN[1]}}, {8{WB_SEL_IN[0]}}};

    always_comb begin
        bus.hit   = 1'b0;
        bus.rdata = 16'h0000;
        case (bus.index)
            `RX_ENABLE_OFFSET: begin
                bus.hit   = 1'b1;
                bus.rdata = q.input_receiver_enable;
            end
            `RX_DELAY_OFFSET: begin
                bus.hit   = 1'b1;
                bus.rdata = q.receiver_delay_control;
            end
            default: begin
                bus.hit   = 1'b0;
            end
        endcase
    end

    always_comb begin
        next_q = q;
        if (bus.wr && bus.index == `RX_ENABLE_OFFSET) begin
            next_q.input_receiver_enable = (q.input_receiver_enable & ~(lane_mask
                & `RX_ENABLE_WRITE_MASK)) | (bus.wdata & lane_mask & `RX_ENABLE_WRITE_MASK);
        end
        if (bus.wr && bus.index == `RX_DELAY_OFFSET) begin
            next_q.receiver_delay_control = (q.receiver_delay_control & ~(lane_mask
                & `RX_DELAY_WRITE_MASK)) | (bus.wdata & lane_mask & `RX_DELAY_WRITE_MASK);
        end
    end

    always_ff @(posedge CORE_CLK_IN) begin
        if (!RESET_N_IN) begin
            q.input_receiver_enable  <= `RX_ENABLE_RESET;
            q.receiver_delay_control <= `RX_DELAY_RESET;
        end else begin
            q <= next_q;
        end
    end

    // Outputs are the register bits themselves; the analog side decodes mode
    assign PORT_A_DATA_PINS_EN_OUT = q.input_receiver_enable[`PORT_A_EN_HI:`PORT_A_EN_LO];
    assign PORT_B_DATA_PINS_EN_OUT = q.input_receiver_enable[`PORT_B_EN_HI:`PORT_B_EN_LO];
    // Code counts 80 ps steps, zero means no added delay
    assign PORT_A_DATA_DELAY_OUT   = q.receiver_delay_control[`DATA_DLY_A_HI:`DATA_DLY_A_LO];
    assign SYNC_OR_PORT_A_CLOCK_DELAY_OUT =
        q.receiver_delay_control[`CLK_DLY_A_HI:`CLK_DLY_A_LO];
    assign SHARED_OR_PORT_B_DATA_DELAY_OUT =
        q.receiver_delay_control[`DATA_DLY_B_HI:`DATA_DLY_B_LO];
    assign SHARED_OR_PORT_B_CLOCK_DELAY_OUT =
        q.receiver_delay_control[`CLK_DLY_B_HI:`CLK_DLY_B_LO];
    assign EXT_REF_ENABLE_OUT      = q.receiver_delay_control[`EXT_REF_BIT];
    // No check of sync mode here; that ordering is software's job
    assign DUAL_CLOCK_ENABLE_OUT   = q.receiver_delay_control[`DUAL_CLOCK_BIT];

    property p_enable_reset;
        @(posedge CORE_CLK_IN) !RESET_N_IN |=> q.input_receiver_enable == 16'h3FFF;
    endproperty
    a_enable_reset: assert property (p_enable_reset) else $error("enable reset wrong");

    property p_delay_reset;
        @(posedge CORE_CLK_IN) !RESET_N_IN |=> q.receiver_delay_control == 16'h0000;
    endproperty
    a_delay_reset: assert property (p_delay_reset) else $error("delay reset wrong");

    property p_enable_write;
        @(posedge CORE_CLK_IN) disable iff (!RESET_N_IN)
        bus.wr && bus.index == 4'h2 && WB_SEL_IN == 4'hF
        |=> PORT_A_DATA_PINS_EN_OUT == $past(WB_DAT_IN[13:7])
            && PORT_B_DATA_PINS_EN_OUT == $past(WB_DAT_IN[6:0]);
    endproperty
    a_enable_write: assert property (p_enable_write) else $error("enable write lost");

    property p_port_map;
        @(posedge CORE_CLK_IN) disable iff (!RESET_N_IN)
        bus.rd && bus.index == `RX_ENABLE_OFFSET
        |=> WB_DAT_OUT == {18'h00000, $past(PORT_A_DATA_PINS_EN_OUT),
            $past(PORT_B_DATA_PINS_EN_OUT)};
    endproperty
    a_port_map: assert property (p_port_map) else $error("port map wrong");

    property p_reserved_zero;
        @(posedge CORE_CLK_IN) disable iff (!RESET_N_IN)
        q.input_receiver_enable[15:14] == 2'b00 && q.receiver_delay_control[2:1] == 2'b00;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

    property p_delay_write;
        @(posedge CORE_CLK_IN) disable iff (!RESET_N_IN)
        bus.wr && bus.index == 4'h3 && WB_SEL_IN == 4'hF
        |=> PORT_A_DATA_DELAY_OUT == $past(WB_DAT_IN[15:13])
            && SYNC_OR_PORT_A_CLOCK_DELAY_OUT == $past(WB_DAT_IN[12:10])
            && SHARED_OR_PORT_B_DATA_DELAY_OUT == $past(WB_DAT_IN[9:7]);
    endproperty
    a_delay_write: assert property (p_delay_write) else $error("delay write lost");

    property p_clock_fields;
        @(posedge CORE_CLK_IN) disable iff (!RESET_N_IN)
        bus.wr && bus.index == 4'h3 && WB_SEL_IN == 4'hF
        |=> SHARED_OR_PORT_B_CLOCK_DELAY_OUT == $past(WB_DAT_IN[6:4])
            && EXT_REF_ENABLE_OUT == $past(WB_DAT_IN[3])
            && DUAL_CLOCK_ENABLE_OUT == $past(WB_DAT_IN[0]);
    endproperty
    a_clock_fields: assert property (p_clock_fields) else $error("control write lost");

    sequence s_request;
        WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT;
    endsequence
    property p_read_back;
        @(posedge CORE_CLK_IN) disable iff (!RESET_N_IN)
        s_request ##0 (!WB_WE_IN && WB_ADR_IN[5:2] == 4'h3)
        |=> WB_ACK_OUT && WB_DAT_OUT == {16'h0000, $past(q.receiver_delay_control)};
    endproperty
    a_read_back: assert property (p_read_back) else $error("read back wrong");

    property p_hold;
        @(posedge CORE_CLK_IN) disable iff (!RESET_N_IN)
        !bus.wr |=> $stable(q);
    endproperty
    a_hold: assert property (p_hold) else $error("register changed without write");

    sequence s_answer;
        WB_ACK_OUT ##1 !WB_ACK_OUT;
    endsequence
    property p_answer;
        @(posedge CORE_CLK_IN) disable iff (!RESET_N_IN)
        s_request |=> s_answer;
    endproperty
    // A held strobe in the ack cycle is not taken again
    a_answer: assert property (p_answer) else $error("ack not a single pulse");

    property p_ack_cause;
        @(posedge CORE_CLK_IN) disable iff (!RESET_N_IN)
        !(WB_CYC_IN && WB_STB_IN) |=> !WB_ACK_OUT;
    endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("stray ack");

    property p_unmapped_read;
        @(posedge CORE_CLK_IN) disable iff (!RESET_N_IN)
        bus.rd && bus.index != `RX_ENABLE_OFFSET && bus.index != `RX_DELAY_OFFSET
        |=> WB_ACK_OUT && WB_DAT_OUT == 32'h00000000;
    endproperty
    a_unmapped_read: assert property (p_unmapped_read) else $error("stray read data");

    property p_unmapped_write;
        @(posedge CORE_CLK_IN) disable iff (!RESET_N_IN)
        bus.wr && bus.index != `RX_ENABLE_OFFSET && bus.index != `RX_DELAY_OFFSET
        |=> $stable(q);
    endproperty
    a_unmapped_write: assert property (p_unmapped_write) else $error("stray write");

    property p_enable_read;
        @(posedge CORE_CLK_IN) disable iff (!RESET_N_IN)
        s_request ##0 (!WB_WE_IN && WB_ADR_IN[5:2] == `RX_ENABLE_OFFSET)
        |=> WB_ACK_OUT && WB_DAT_OUT == {16'h0000, $past(q.input_receiver_enable)};
    endproperty
    a_enable_read: assert property (p_enable_read) else $error("enable read wrong");

    // Every field must sit where software reads it back
    property p_delay_map;
        @(posedge CORE_CLK_IN) disable iff (!RESET_N_IN)
        bus.rd && bus.index == `RX_DELAY_OFFSET
        |=> WB_DAT_OUT == {16'h0000, $past(PORT_A_DATA_DELAY_OUT),
            $past(SYNC_OR_PORT_A_CLOCK_DELAY_OUT), $past(SHARED_OR_PORT_B_DATA_DELAY_OUT),
            $past(SHARED_OR_PORT_B_CLOCK_DELAY_OUT), $past(EXT_REF_ENABLE_OUT), 2'b00,
            $past(DUAL_CLOCK_ENABLE_OUT)};
    endproperty
    a_delay_map: assert property (p_delay_map) else $error("delay field map wrong");

    property p_reset_outputs;
        @(posedge CORE_CLK_IN) !RESET_N_IN
        |=> !WB_ACK_OUT && WB_DAT_OUT == 32'h00000000
            && PORT_A_DATA_PINS_EN_OUT == 7'h7F && PORT_B_DATA_PINS_EN_OUT == 7'h7F
            && PORT_A_DATA_DELAY_OUT == 3'h0 && SYNC_OR_PORT_A_CLOCK_DELAY_OUT == 3'h0
            && SHARED_OR_PORT_B_DATA_DELAY_OUT == 3'h0
            && SHARED_OR_PORT_B_CLOCK_DELAY_OUT == 3'h0
            && !EXT_REF_ENABLE_OUT && !DUAL_CLOCK_ENABLE_OUT;
    endproperty
    a_reset_outputs: assert property (p_reset_outputs) else $error("reset outputs wrong");

    property p_dat_hold;
        @(posedge CORE_CLK_IN) disable iff (!RESET_N_IN)
        !(WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT) |=> $stable(WB_DAT_OUT);
    endproperty
    a_dat_hold: assert property (p_dat_hold) else $error("read data moved");

    localparam reg_word_t ENABLE_WRITABLE = `RX_ENABLE_WRITE_MASK;
    localparam reg_word_t DELAY_WRITABLE  = `RX_DELAY_WRITE_MASK;

    // Per-bit checks: a lane that is off, or a reserved bit, never moves
    for (genvar i = 0; i < 16; i++) begin : g_bit
        if (ENABLE_WRITABLE[i]) begin : g_en
            property p_en_bit;
                @(posedge CORE_CLK_IN) disable iff (!RESET_N_IN)
                bus.wr && bus.index == `RX_ENABLE_OFFSET && WB_SEL_IN[i / 8]
                |=> q.input_receiver_enable[i] == $past(WB_DAT_IN[i]);
            endproperty
            a_en_bit: assert property (p_en_bit) else $error("enable bit lost");

            property p_en_hold;
                @(posedge CORE_CLK_IN) disable iff (!RESET_N_IN)
                !(bus.wr && bus.index == `RX_ENABLE_OFFSET && WB_SEL_IN[i / 8])
                |=> $stable(q.input_receiver_enable[i]);
            endproperty
            a_en_hold: assert property (p_en_hold) else $error("enable bit moved");
        end else begin : g_en_rsvd
            property p_en_rsvd;
                @(posedge CORE_CLK_IN) disable iff (!RESET_N_IN)
                bus.wr && bus.index == `RX_ENABLE_OFFSET |=> !q.input_receiver_enable[i];
            endproperty
            a_en_rsvd: assert property (p_en_rsvd) else $error("enable reserved set");
        end

        if (DELAY_WRITABLE[i]) begin : g_dly
            property p_dly_bit;
                @(posedge CORE_CLK_IN) disable iff (!RESET_N_IN)
                bus.wr && bus.index == `RX_DELAY_OFFSET && WB_SEL_IN[i / 8]
                |=> q.receiver_delay_control[i] == $past(WB_DAT_IN[i]);
            endproperty
            a_dly_bit: assert property (p_dly_bit) else $error("delay bit lost");

            property p_dly_hold;
                @(posedge CORE_CLK_IN) disable iff (!RESET_N_IN)
                !(bus.wr && bus.index == `RX_DELAY_OFFSET && WB_SEL_IN[i / 8])
                |=> $stable(q.receiver_delay_control[i]);
            endproperty
            a_dly_hold: assert property (p_dly_hold) else $error("delay bit moved");
        end else begin : g_dly_rsvd
            property p_dly_rsvd;
                @(posedge CORE_CLK_IN) disable iff (!RESET_N_IN)
                bus.wr && bus.index == `RX_DELAY_OFFSET |=> !q.receiver_delay_control[i];
            endproperty
            a_dly_rsvd: assert property (p_dly_rsvd) else $error("delay reserved set");
        end
    end
endmodule
`default_nettype wire

// file: rtl/lvds_rx_cfg.svh
/*
 Constants for the input receiver configuration registers: offsets, field
 positions, reset values and delay timing. Included by bare name.
*/
`ifndef LVDS_RX_CFG_SVH
`define LVDS_RX_CFG_SVH

`define RX_ENABLE_OFFSET      4'h2
`define RX_DELAY_OFFSET       4'h3
`define RX_ENABLE_RESET       16'h3FFF
`define RX_DELAY_RESET        16'h0000
`define RX_ENABLE_WRITE_MASK  16'h3FFF
`define RX_DELAY_WRITE_MASK   16'hFFF9
`define PORT_A_EN_HI          13
`define PORT_A_EN_LO          7
`define PORT_B_EN_HI          6
`define PORT_B_EN_LO          0
`define DATA_DLY_A_HI         15
`define DATA_DLY_A_LO         13
`define CLK_DLY_A_HI          12
`define CLK_DLY_A_LO          10
`define DATA_DLY_B_HI         9
`define DATA_DLY_B_LO         7
`define CLK_DLY_B_HI          6
`define CLK_DLY_B_LO          4
`define EXT_REF_BIT           3
`define DUAL_CLOCK_BIT        0
`define DELAY_STEP_PS         80

`endif

// file: rtl/lvds_rx_pkg.sv
/*
 Types shared by the receiver configuration bank and its bus port.
 Assumes the constants header sits beside it.
*/
package lvds_rx_pkg;
    typedef logic [15:0] reg_word_t;
    typedef logic [2:0]  delay_code_t;
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b00,
        BUS_ACK  = 2'b01
    } bus_state_e;
endpackage

// file: rtl/lvds_rx_bus_if.sv
/*
 Internal register access channel between the bus slave and the register
 bank. Assumes one clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
interface lvds_rx_bus_if;
    logic        wr;
    logic        rd;
    logic [3:0]  index;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic        hit;
    modport slave  (input wr, input rd, input index, input wdata, output rdata, output hit);
    modport master (output wr, output rd, output index, output wdata, input rdata, input hit);
endinterface
`default_nettype wire

// file: rtl/lvds_rx_wb_slave.sv
/*
 Classic Wishbone slave: one-cycle request decode, registered ack one
 cycle after strobe. Assumes 32-bit words, byte addresses, synchronous reset.
*/
`timescale 1ns/1ps
`default_nettype none
module lvds_rx_wb_slave
    import lvds_rx_pkg::*;
(
    input  wire logic        clk_in,
    input  wire logic        reset_n_in,
    input  wire logic        cyc_in,
    input  wire logic        stb_in,
    input  wire logic        we_in,
    input  wire logic [5:0]  adr_in,
    input  wire logic [31:0] dat_in,
    output var  logic [31:0] dat_out,
    output var  logic        ack_out,
    lvds_rx_bus_if.master    bus
);
    typedef struct packed {
        bus_state_e  state;
        logic [31:0] dat;
        logic        ack;
    } wb_state_s;

    wb_state_s q;
    wb_state_s next_q;
    logic      req;

    // Access happens only in the request's first cycle, so no double write
    assign req       = cyc_in && stb_in && (q.state == BUS_IDLE);
    assign bus.wr    = req && we_in;
    assign bus.rd    = req && !we_in;
    assign bus.index = adr_in[5:2];
    assign bus.wdata = dat_in[15:0];

    always_comb begin
        next_q = q;
        next_q.ack = 1'b0;
        case (q.state)
            BUS_IDLE: begin
                if (req) begin
                    next_q.ack   = 1'b1;
                    next_q.state = BUS_ACK;
                    // Unmapped reads return zero, unmapped writes dropped
                    next_q.dat   = bus.hit ? {16'h0000, bus.rdata} : 32'h00000000;
                end
            end
            BUS_ACK: begin
                next_q.state = BUS_IDLE;
            end
            default: begin
                next_q.state = BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            q <= '{state: BUS_IDLE, dat: 32'h00000000, ack: 1'b0};
        end else begin
            q <= next_q;
        end
    end

    assign dat_out = q.dat;
    assign ack_out = q.ack;
endmodule
`default_nettype wire

// file: verification/lvds_rx_config_regs_tb.sv
/*
 Self-checking bench for the receiver configuration bank.
 Waits for the ack within 20 cycles; assumes a synchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module lvds_rx_config_regs_tb
    import lvds_rx_pkg::*;
;
    logic        clk;
    logic        rst_n;
    logic        cyc;
    logic        stb;
    logic        we;
    logic [5:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
    logic [31:0] rdat;
    logic        ack;
    logic [6:0]  pa_en;
    logic [6:0]  pb_en;
    logic [2:0]  dly_a;
    logic [2:0]  clk_a;
    logic [2:0]  dly_b;
    logic [2:0]  clk_b;
    logic        ext_ref;
    logic        dual;
    reg_word_t   en_m;
    reg_word_t   dly_m;
    int          n_errors;
    int          checks;

    lvds_rx_config_regs dut (.CORE_CLK_IN(clk), .RESET_N_IN(rst_n), .WB_CYC_IN(cyc),
        .WB_STB_IN(stb), .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(sel), .WB_DAT_IN(dat),
        .WB_DAT_OUT(rdat), .WB_ACK_OUT(ack), .PORT_A_DATA_PINS_EN_OUT(pa_en),
        .PORT_B_DATA_PINS_EN_OUT(pb_en), .PORT_A_DATA_DELAY_OUT(dly_a),
        .SYNC_OR_PORT_A_CLOCK_DELAY_OUT(clk_a), .SHARED_OR_PORT_B_DATA_DELAY_OUT(dly_b),
        .SHARED_OR_PORT_B_CLOCK_DELAY_OUT(clk_b), .EXT_REF_ENABLE_OUT(ext_ref),
        .DUAL_CLOCK_ENABLE_OUT(dual));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic check_val(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic report_and_stop;
        $display("errors %0d checks %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Byte lanes merge, then reserved bits are forced low
    function automatic reg_word_t merge(reg_word_t old, logic [31:0] d, logic [3:0] s,
                                        reg_word_t mask);
        reg_word_t r;
        r = old;
        if (s[0]) r[7:0] = d[7:0];
        if (s[1]) r[15:8] = d[15:8];
        return r & mask;
    endfunction

    task automatic check_outs;
        check_val("port_a_en", 32'(en_m[13:7]), 32'(pa_en));
        check_val("port_b_en", 32'(en_m[6:0]), 32'(pb_en));
        check_val("port_a_dly", 32'(dly_m[15:13]), 32'(dly_a));
        check_val("clk_a_dly", 32'(dly_m[12:10]), 32'(clk_a));
        check_val("data_b_dly", 32'(dly_m[9:7]), 32'(dly_b));
        check_val("clk_b_dly", 32'(dly_m[6:4]), 32'(clk_b));
        check_val("ext_ref", 32'(dly_m[3]), 32'(ext_ref));
        check_val("dual_clk", 32'(dly_m[0]), 32'(dual));
    endtask

    // Waits on ack under a bound; the answer time is never assumed
    task automatic access(input logic w, input logic [5:0] a, input logic [31:0] d,
                          input logic [3:0] s);
        int          n;
        logic [31:0] exp;
        exp = (a[5:2] == 4'h2) ? {16'h0000, en_m} : (a[5:2] == 4'h3) ? {16'h0000, dly_m} : 32'h0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= a;
        dat <= d;
        sel <= s;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        cyc <= 1'b0;
        stb <= 1'b0;
        if (ack !== 1'b1) begin
            n_errors++;
            report_and_stop();
        end
        if (!w) check_val("read_data", exp, rdat);
        if (w && a[5:2] == 4'h2) en_m = merge(en_m, d, s, 16'h3FFF);
        if (w && a[5:2] == 4'h3) dly_m = merge(dly_m, d, s, 16'hFFF9);
        check_outs();
    endtask

    initial begin
        logic [5:0] a;
        rst_n = 1'b0;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 6'h00;
        sel = 4'h0;
        dat = 32'h0;
        en_m = 16'h3FFF;
        dly_m = 16'h0000;
        n_errors = 0;
        checks = 0;
        void'($urandom(32'h2828b6d8));
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        check_outs();
        access(1'b0, 6'h08, 32'h0, 4'hF);
        access(1'b0, 6'h0C, 32'h0, 4'hF);
        access(1'b1, 6'h08, 32'hFFFFFFFF, 4'hF);
        access(1'b1, 6'h0C, 32'hFFFFFFFF, 4'hF);
        access(1'b0, 6'h08, 32'h0, 4'hF);
        access(1'b0, 6'h0C, 32'h0, 4'hF);
        for (int i = 0; i < 14; i++) begin
            access(1'b1, 6'h08, 32'h1 << i, 4'h3);
        end
        for (int c = 0; c < 8; c++) begin
            access(1'b1, 6'h0C, {16'h0, 3'(c), 3'(c), 3'(c), 3'(c), c[1], 2'b11, c[0]}, 4'h3);
        end
        // Random traffic, unmapped indices and partial byte lanes included
        for (int k = 0; k < 60; k++) begin
            a = {4'($urandom % 16), 2'b00};
            access(1'($urandom % 2), a, $urandom, 4'($urandom % 16));
            access(1'b0, a, 32'h0, 4'hF);
        end
        access(1'b1, 6'h08, 32'h0, 4'h3);
        access(1'b1, 6'h0C, 32'hFFFF, 4'h3);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        en_m = 16'h3FFF;
        dly_m = 16'h0000;
        @(posedge clk);
        check_outs();
        access(1'b0, 6'h08, 32'h0, 4'hF);
        access(1'b0, 6'h0C, 32'h0, 4'hF);
        report_and_stop();
    end
endmodule
`default_nettype wire
